//--- rtl/scd_pkg.sv
/*
 * Shared constants, types and helpers for the static-column DRAM module
 * controller: timing figures in ns, their cycle counts, pin widths,
 * the request carrier and the controller state codes.
 * Assumes a single 100 MHz system clock; all cycle counts but C_MARGIN are derived from it.
 */
// Operation
// - wait 100 us, then eight strobe cycles
// - column strobe high before row falls
// - write strobe held high after read
// - early write setup and hold met
// - read-modify-write only on ninth bit
// - static-column accesses spaced by cycle minimum
// - static-column read-write cycle minimum length
// - row strobe width bounded in static column
// - second write no sooner than row delay
// - column address held after previous write
// - all 512 rows refreshed every 8 ms
// - column strobe precedes row for refresh
package scd_pkg;

	// Clock and conversion helpers
	localparam int unsigned CLK_MHZ = 100;

	// Least time: round up, never below one cycle
	function automatic int unsigned cyc_min(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	// Longest time: round down, never below one cycle
	function automatic int unsigned cyc_max(input int unsigned ns);
		int unsigned c;
		c = (ns * CLK_MHZ) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : cyc_max

	// Pin and word widths
	localparam int unsigned ADDR_W  = 10;  // Multiplexed address pins
	localparam int unsigned DQ_W    = 8;   // Common data pins
	localparam int unsigned WORD_W  = 9;   // Eight data bits plus ninth
	localparam int unsigned LADDR_W = 20;  // Row and column together

	// Start-up and refresh figures
	localparam int unsigned PWRUP_US   = 100;
	localparam int unsigned INIT_CBR   = 8;
	localparam int unsigned REF_MS     = 8;
	localparam int unsigned REF_ROWS   = 512;
	localparam int unsigned RASC_MAX_NS = 100000;

	// Timing figures in ns (fastest grade)
	localparam int unsigned T_RAH_NS     = 12;  // Row address hold
	localparam int unsigned T_RCD_NS     = 25;  // row_to_col_strobe_delay
	localparam int unsigned T_RAC_NS     = 80;  // access_from_row
	localparam int unsigned T_AA_NS      = 45;  // access_from_col_addr
	localparam int unsigned T_RP_NS      = 70;  // Row precharge
	localparam int unsigned T_RASMIN_NS  = 80;  // sc_row_active_width min
	localparam int unsigned T_CSR_NS     = 10;  // Strobe setup for refresh
	localparam int unsigned T_CHR_NS     = 15;  // Strobe hold for refresh
	localparam int unsigned T_WCH_NS     = 15;  // Write hold
	localparam int unsigned T_RWL_NS     = 25;  // Write to row lead
	localparam int unsigned T_WP_NS      = 15;  // Write pulse
	localparam int unsigned T_RSW_NS     = 95;  // row_to_second_write
	localparam int unsigned T_PWH_NS     = 90;  // Address hold after write
	localparam int unsigned T_SC_NS      = 50;  // sc_read_cycle_min

	// Cycle counts
	localparam int unsigned C_RAH    = cyc_min(T_RAH_NS);
	localparam int unsigned C_RCD    = cyc_min(T_RCD_NS);
	localparam int unsigned C_RAC    = cyc_min(T_RAC_NS);
	localparam int unsigned C_AA     = cyc_min(T_AA_NS);
	localparam int unsigned C_RP     = cyc_min(T_RP_NS);
	localparam int unsigned C_RASMIN = cyc_min(T_RASMIN_NS);
	localparam int unsigned C_CSR    = cyc_min(T_CSR_NS);
	localparam int unsigned C_CHR    = cyc_min(T_CHR_NS);
	localparam int unsigned C_WCH    = cyc_min(T_WCH_NS);
	localparam int unsigned C_RWL    = cyc_min(T_RWL_NS);
	localparam int unsigned C_WP     = cyc_min(T_WP_NS);
	localparam int unsigned C_RSW    = cyc_min(T_RSW_NS);
	localparam int unsigned C_PWH    = cyc_min(T_PWH_NS);
	localparam int unsigned C_SC     = cyc_min(T_SC_NS);
	localparam int unsigned C_MARGIN = 16;  // Headroom before row limit

	// Request carrier: ninth bit sits on top of the data byte
	typedef struct packed {
		logic                 write;  // Store rather than fetch
		logic                 rmw;    // Ninth-bit read-modify-write
		logic [LADDR_W-1:0]   addr;   // Row in upper, column in lower
		logic [WORD_W-1:0]    wdata;  // Bit 8 is the ninth bit
	} scd_req_t;

	// Controller states, one-hot
	typedef enum logic [12:0] {
		ST_PWR     = 13'h0001,
		ST_IDLE    = 13'h0002,
		ST_CBR_CS  = 13'h0004,
		ST_CBR_RAS = 13'h0008,
		ST_ROW     = 13'h0010,
		ST_COL     = 13'h0020,
		ST_ACC     = 13'h0040,
		ST_RMW_WE  = 13'h0080,
		ST_OPEN    = 13'h0100,
		ST_SC      = 13'h0200,
		ST_SC_WE   = 13'h0400,
		ST_PRE     = 13'h0800,
		ST_SPARE   = 13'h1000
	} scd_state_t;

	// Row half of a linear address
	function automatic logic [ADDR_W-1:0] row_of(
		input logic [LADDR_W-1:0] a);
		return a[LADDR_W-1:ADDR_W];
	endfunction : row_of

	// Column half of a linear address
	function automatic logic [ADDR_W-1:0] col_of(
		input logic [LADDR_W-1:0] a);
		return a[ADDR_W-1:0];
	endfunction : col_of

endpackage : scd_pkg

//--- rtl/scd_timer.sv
/*
 * Down-counter used to time the strobe setup, hold, pulse and precharge intervals of the controller.
 * Assumes the caller loads a cycle count and waits for done.
 */
`timescale 1ns/1ps
module scd_timer #(
	parameter int unsigned W        = 16,  // Counter width
	parameter int unsigned INIT_VAL = 1    // Count running out of reset
) (
	input  wire logic         clk,    // System clock
	input  wire logic         rst_n,  // Asynchronous reset, active low
	input  wire logic         load,   // Start a new interval
	input  wire logic [W-1:0] value,  // Interval length in cycles
	output logic              done    // Interval has expired
);
	import scd_pkg::*;

	logic [W-1:0] cnt_q;  // Cycles left
	logic [W-1:0] cnt_d;  // Next count

	// Reload or count down, stopping at zero
	always_comb
	begin
		cnt_d = cnt_q;
		if (load)
			cnt_d = value;
		else if (cnt_q != '0)
			cnt_d = cnt_q - 1'b1;
	end

	// Register the count; reset starts the power-up interval
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= W'(INIT_VAL);
		else
			cnt_q <= cnt_d;
	end

	assign done = (cnt_q == '0);
endmodule : scd_timer

//--- rtl/scd_ref_sched.sv
/*
 * Refresh scheduler: a divider emits one tick per row interval and a
 * sticky flag holds the refresh debt until the controller pays it.
 * Assumes one refresh is always served within one interval.
 */
`timescale 1ns/1ps
module scd_ref_sched #(
	parameter int unsigned INTERVAL = 1562  // Cycles between refreshes
) (
	input  wire logic clk,    // System clock
	input  wire logic rst_n,  // Asynchronous reset, active low
	input  wire logic en,     // Scheduling allowed
	input  wire logic ack,    // A refresh cycle was issued
	output logic      due     // A refresh is owed
);
	import scd_pkg::*;

	logic [23:0] div_q;  // Interval divider
	logic [23:0] div_d;  // Next divider value
	logic        tick;   // One-cycle pulse per interval
	logic        due_q;  // Debt flag
	logic        due_d;  // Next debt flag

	// Divider and debt flag; a tick in the ack cycle is kept
	always_comb
	begin
		tick  = en && (div_q == 24'(INTERVAL - 1));
		div_d = (!en || tick) ? 24'h000000 : div_q + 24'h000001;
		due_d = tick || (due_q && !ack);
	end

	// Register divider and flag
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_q <= 24'h000000;
			due_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			due_q <= due_d;
		end
	end

	assign due = due_q;
endmodule : scd_ref_sched

//--- rtl/scd_ctrl.sv
/*
 * Host-side controller for a 1M x 9 static-column DRAM module. It takes
 * word requests, runs power-up, refresh, random, static-column and
 * ninth-bit read-modify-write cycles, and drives the module's strobes.
 * Assumes module pins are synchronous to SYS_CLK and that the board
 * resolves the shared data wires from DQ_OE.
 */
`timescale 1ns/1ps
module scd_ctrl
	import scd_pkg::*;
#(
	parameter int unsigned PWRUP_CYC      = PWRUP_US * CLK_MHZ,
	parameter int unsigned REF_PERIOD_CYC = REF_MS * 1000 * CLK_MHZ,
	parameter int unsigned RASC_MAX_CYC   = cyc_max(RASC_MAX_NS)
) (
	input  wire logic                     SYS_CLK,      // System clock
	input  wire logic                     RST_N,        // Reset, low
	input  wire logic                     REQ_VALID,    // Request offered
	output logic                          REQ_READY,    // Request taken
	input  wire scd_pkg::scd_req_t        REQ,          // Request body
	output logic                          RSP_VALID,    // Access done
	output logic [scd_pkg::WORD_W-1:0]    RSP_DATA,     // Read word
	output logic                          INIT_DONE,    // Start-up over
	output logic                          RAS_N,        // Row strobe
	output logic                          CS_N,         // Column strobe
	output logic                          NINTH_BIT_STROBE_N, // Bit 9
	output logic                          WE_N,         // Write strobe
	output logic [scd_pkg::ADDR_W-1:0]    ADDR,         // Mux address
	input  wire logic [scd_pkg::DQ_W-1:0] DQ_I,         // Data from pins
	output logic [scd_pkg::DQ_W-1:0]      DQ_O,         // Data to pins
	output logic                          DQ_OE,        // Drive data
	output logic                          D9_TO_MEM,    // Ninth bit in
	input  wire logic                     D9_FROM_MEM   // Ninth bit out
);
	import scd_pkg::*;

	// Parameters the counters cannot hold are refused
	if (PWRUP_CYC < 2 || PWRUP_CYC > 65535 ||
		RASC_MAX_CYC > 65535 || RASC_MAX_CYC <= C_MARGIN + C_RASMIN ||
		REF_PERIOD_CYC / REF_ROWS < 64)
	begin : g_bad_param
		$error("scd_ctrl: timing parameter out of range");
	end

	localparam int unsigned REF_INT = REF_PERIOD_CYC / REF_ROWS;
	localparam logic [15:0] RASC_LIM = 16'(RASC_MAX_CYC - C_MARGIN);

	scd_state_t          st_q, st_d;         // Controller state
	scd_req_t            req_q, req_d;       // Request in service
	logic [ADDR_W-1:0]   row_q, row_d;       // Row held open
	logic [ADDR_W-1:0]   addr_q, addr_d;     // Address pins
	logic                ras_q, ras_d;       // Row strobe pin
	logic                cs_q, cs_d;         // Column strobe pin
	logic                s9_q, s9_d;         // Ninth strobe pin
	logic                we_q, we_d;         // Write strobe pin
	logic                oe_q, oe_d;         // Data drive enable
	logic [DQ_W-1:0]     dqo_q, dqo_d;       // Data driven
	logic                d9_q, d9_d;         // Ninth bit driven
	logic                rspv_q, rspv_d;     // Completion pulse
	logic [WORD_W-1:0]   rsp_q, rsp_d;       // Captured word
	logic [3:0]          icnt_q, icnt_d;     // Start-up refreshes done
	logic                idone_q, idone_d;   // Start-up finished
	logic [15:0]         age_q, age_d;       // Cycles since row fell
	logic [3:0]          pwh_q, pwh_d;       // Cycles since write fell
	logic                t_load;             // Timer reload
	logic [15:0]         t_val;              // Timer reload value
	logic                t_done;             // Timer expired
	logic                ref_due;            // Refresh owed
	logic                ref_ack;            // Refresh issued
	logic                sc_hit;             // Request fits open row
	logic                pwh_ok;             // Column may move again
	logic                must_close;         // Open row has to end

	// Interval timer, starting with the power-up wait
	scd_timer #(
		.W        (16),
		.INIT_VAL (PWRUP_CYC)
	) u_timer (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.load  (t_load),
		.value (t_val),
		.done  (t_done)
	);

	// Refresh debt, only counted once start-up is over
	scd_ref_sched #(
		.INTERVAL (REF_INT)
	) u_ref (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.en    (idone_q),
		.ack   (ref_ack),
		.due   (ref_due)
	);

	// Static-column eligibility; moving the column too early after a
	// write would corrupt it, so writes hold the port a while
	always_comb
	begin
		pwh_ok     = (pwh_q >= 4'(C_PWH));
		must_close = ref_due || (age_q >= RASC_LIM);
		sc_hit     = (row_of(REQ.addr) == row_q) && !REQ.rmw;
		REQ_READY  = ((st_q == ST_IDLE) && idone_q && !ref_due) ||
			((st_q == ST_OPEN) && sc_hit && pwh_ok && !must_close);
	end

	// Next-state logic for the sequencer and every pin
	always_comb
	begin
		st_d    = st_q;
		req_d   = req_q;
		row_d   = row_q;
		addr_d  = addr_q;
		ras_d   = ras_q;
		cs_d    = cs_q;
		s9_d    = s9_q;
		we_d    = we_q;
		oe_d    = oe_q;
		dqo_d   = dqo_q;
		d9_d    = d9_q;
		rspv_d  = 1'b0;
		rsp_d   = rsp_q;
		icnt_d  = icnt_q;
		idone_d = idone_q;
		t_load  = 1'b0;
		t_val   = 16'h0000;
		ref_ack = 1'b0;
		case (st_q)
			// Power-up pause runs from reset
			ST_PWR:
				if (t_done)
					st_d = ST_IDLE;
			// Refresh first, then new rows
			ST_IDLE:
				if (!idone_q || ref_due)
				begin
					cs_d   = 1'b0;
					s9_d   = 1'b0;
					we_d   = 1'b1;
					t_load = 1'b1;
					t_val  = 16'(C_CSR);
					st_d   = ST_CBR_CS;
				end
				else if (REQ_VALID)
				begin
					req_d  = REQ;
					row_d  = row_of(REQ.addr);
					addr_d = row_of(REQ.addr);  // Setup before row fall
					st_d   = ST_ROW;
				end
			// Strobe leads row for refresh; internal counter walks rows
			ST_CBR_CS:
				if (t_done)
				begin
					ras_d  = 1'b0;
					t_load = 1'b1;
					t_val  = 16'(C_CHR);
					st_d   = ST_CBR_RAS;
				end
			ST_CBR_RAS:
			begin
				if (t_done && !cs_q)
				begin
					cs_d = 1'b1;
					s9_d = 1'b1;
				end
				if (cs_q && age_q >= 16'(C_RASMIN))
				begin
					ras_d   = 1'b1;
					ref_ack = idone_q;
					icnt_d  = icnt_q + 4'h1;
					if (icnt_q == 4'(INIT_CBR - 1))
						idone_d = 1'b1;
					t_load  = 1'b1;
					t_val   = 16'(C_RP);
					st_d    = ST_PRE;
				end
			end
			// Row address latched on row strobe
			ST_ROW:
			begin
				ras_d  = 1'b0;
				t_load = 1'b1;
				t_val  = 16'(C_RAH);
				st_d   = ST_COL;
			end
			// Column address; early write sets up data and write
			ST_COL:
				if (t_done)
				begin
					addr_d = col_of(req_q.addr);
					if (req_q.write && !req_q.rmw)
					begin
						we_d  = 1'b0;
						oe_d  = 1'b1;
						dqo_d = req_q.wdata[DQ_W-1:0];
						d9_d  = req_q.wdata[WORD_W-1];
					end
					t_load = 1'b1;
					t_val  = 16'(C_RCD - C_RAH);
					st_d   = ST_ACC;
				end
			// Column strobe, then access or write completion
			ST_ACC:
				if (s9_q)
				begin
					if (t_done)
					begin
						cs_d   = req_q.rmw;
						s9_d   = 1'b0;
						t_load = 1'b1;
						t_val  = 16'(C_WCH);
					end
				end
				else if (req_q.write && !req_q.rmw)
				begin
					if (t_done)
					begin
						we_d   = 1'b1;
						oe_d   = 1'b0;
						rspv_d = 1'b1;
						st_d   = ST_OPEN;
					end
				end
				else if (age_q >= 16'(C_RAC + 1))
				begin
					// Data chips sit out a ninth-bit rmw: byte reads 0
					rsp_d  = {D9_FROM_MEM, DQ_I & {DQ_W{!req_q.rmw}}};
					rspv_d = !req_q.rmw;
					if (req_q.rmw)
					begin
						we_d   = 1'b0;
						d9_d   = req_q.wdata[WORD_W-1];
						t_load = 1'b1;
						t_val  = 16'(C_RWL);
						st_d   = ST_RMW_WE;
					end
					else
						st_d = ST_OPEN;
				end
			// Delayed write on the ninth bit, then close the row
			ST_RMW_WE:
				if (t_done)
				begin
					rspv_d = 1'b1;
					ras_d  = 1'b1;
					cs_d   = 1'b1;
					s9_d   = 1'b1;
					we_d   = 1'b1;
					t_load = 1'b1;
					t_val  = 16'(C_RP);
					st_d   = ST_PRE;
				end
			// Row open with strobes low; column moves alone
			ST_OPEN:
				if (REQ_VALID && REQ_READY)
				begin
					req_d  = REQ;
					addr_d = col_of(REQ.addr);
					if (REQ.write)
					begin
						dqo_d = REQ.wdata[DQ_W-1:0];
						d9_d  = REQ.wdata[WORD_W-1];
					end
					t_load = 1'b1;
					t_val  = REQ.write ? 16'h0001 : 16'(C_AA + 1);
					st_d   = ST_SC;
				end
				else if ((must_close || (REQ_VALID && !sc_hit)) &&
					age_q >= 16'(C_RASMIN))
				begin
					ras_d  = 1'b1;
					cs_d   = 1'b1;
					s9_d   = 1'b1;
					we_d   = 1'b1;
					oe_d   = 1'b0;
					t_load = 1'b1;
					t_val  = 16'(C_RP);
					st_d   = ST_PRE;
				end
			// Static-column access; reads last a full cycle minimum
			ST_SC:
				if (!req_q.write)
				begin
					if (t_done)
					begin
						rsp_d  = {D9_FROM_MEM, DQ_I};
						rspv_d = 1'b1;
						st_d   = ST_OPEN;
					end
				end
				else if (t_done && age_q >= 16'(C_RSW))
				begin
					we_d   = 1'b0;
					oe_d   = 1'b1;  // Drive only once outputs turn off
					t_load = 1'b1;
					t_val  = 16'(C_WP);
					st_d   = ST_SC_WE;
				end
			// Write pulse, then release the data pins
			ST_SC_WE:
				if (t_done)
				begin
					we_d   = 1'b1;
					oe_d   = 1'b0;
					rspv_d = 1'b1;
					st_d   = ST_OPEN;
				end
			// Precharge keeps column strobe high before next row
			ST_PRE:
				if (t_done)
					st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// Row age and time since the last write fall, both saturating
	always_comb
	begin
		age_d = ras_q ? 16'h0000 :
			((age_q == 16'hffff) ? age_q : age_q + 16'h0001);
		if (we_q && !we_d)
			pwh_d = 4'h0;
		else
			pwh_d = (pwh_q >= 4'(C_PWH)) ? pwh_q : pwh_q + 4'h1;
	end

	// Register all state; strobes idle high out of reset
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st_q    <= ST_PWR;
			req_q   <= '0;
			row_q   <= '0;
			addr_q  <= '0;
			ras_q   <= 1'b1;
			cs_q    <= 1'b1;
			s9_q    <= 1'b1;
			we_q    <= 1'b1;
			oe_q    <= 1'b0;
			dqo_q   <= '0;
			d9_q    <= 1'b0;
			rspv_q  <= 1'b0;
			rsp_q   <= '0;
			icnt_q  <= 4'h0;
			idone_q <= 1'b0;
			age_q   <= 16'h0000;
			pwh_q   <= 4'(C_PWH);
		end
		else
		begin
			st_q    <= st_d;
			req_q   <= req_d;
			row_q   <= row_d;
			addr_q  <= addr_d;
			ras_q   <= ras_d;
			cs_q    <= cs_d;
			s9_q    <= s9_d;
			we_q    <= we_d;
			oe_q    <= oe_d;
			dqo_q   <= dqo_d;
			d9_q    <= d9_d;
			rspv_q  <= rspv_d;
			rsp_q   <= rsp_d;
			icnt_q  <= icnt_d;
			idone_q <= idone_d;
			age_q   <= age_d;
			pwh_q   <= pwh_d;
		end
	end

	// Pins straight from flip-flops
	assign RAS_N              = ras_q;
	assign CS_N               = cs_q;
	assign NINTH_BIT_STROBE_N = s9_q;
	assign WE_N               = we_q;
	assign ADDR               = addr_q;
	assign DQ_O               = dqo_q;
	assign DQ_OE              = oe_q;
	assign D9_TO_MEM          = d9_q;
	assign RSP_VALID          = rspv_q;
	assign RSP_DATA           = rsp_q;
	assign INIT_DONE          = idone_q;
endmodule : scd_ctrl

//--- bench/scd_mem_model.sv
/*
 Behavioural model of the 1M x 9 static-column memory module.
 Assumes strobes and data arrive registered on the controller clock.
*/
`timescale 1ns/1ps
module scd_mem_model
	import scd_pkg::*;
(
	input  wire logic              clk,    // Controller clock
	input  wire logic              ras_n,  // Row strobe
	input  wire logic              cs_n,   // Column strobe
	input  wire logic              cs9_n,  // Ninth-bit strobe
	input  wire logic              we_n,   // Write strobe
	input  wire logic [ADDR_W-1:0] addr,   // Mux address
	input  wire logic [DQ_W-1:0]   dq_o,   // Data to memory
	input  wire logic              dq_oe,  // Controller drives data
	input  wire logic              d9_in,  // Ninth bit in
	output logic      [DQ_W-1:0]   dq_i,   // Data to controller
	output logic                   d9_out  // Ninth bit out
);
	logic [WORD_W-1:0] mem [0:255];   // Small slice, row and col nibbles
	logic [ADDR_W-1:0] row_q;         // Row taken at strobe fall
	logic              ras_q = 1'b1;  // Last row strobe
	logic              cs9_q = 1'b1;  // Last ninth strobe
	logic              early_q = 1'b1; // Ninth cycle began as write
	logic              we_q = 1'b1;   // Last write strobe
	logic              rd9_q;         // Ninth bit read before write
	logic              junk_q = 1'b0; // Toggles so idle pins never settle
	logic [7:0]        idx;           // Cell index
	assign idx = {row_q[3:0], addr[3:0]};
	// Strobe tracking and cell writes on clock edges
	always @(posedge clk)
	begin
		ras_q  <= ras_n;
		cs9_q  <= cs9_n;
		junk_q <= ~junk_q;
		we_q   <= we_n;
		if (ras_q && !ras_n)
			row_q <= addr;
		if (cs9_q && !cs9_n)
			early_q <= !we_n;
		else if (!we_q && we_n && !cs9_n)
			early_q <= 1'b0;  // Static column: output back on
		if (we_n)
			rd9_q <= mem[idx][8];
		if (!ras_n && !cs_n && !we_n && dq_oe)
			mem[idx][7:0] <= dq_o;
		if (!ras_n && !cs9_n && !we_n)
			mem[idx][8] <= d9_in;
	end
	// Answers at once, inside every access limit; column change alone
	// selects new data
	assign dq_i = (!ras_n && !cs_n && we_n) ? mem[idx][7:0] :
		{4{junk_q, ~junk_q}};
	// Early write leaves the ninth output floating, read-write shows
	// the cell
	assign d9_out = (cs9_n || early_q) ? junk_q :
		(we_n ? mem[idx][8] : rd9_q);
endmodule : scd_mem_model

//--- bench/scd_ctrl_checker.sv
/*
 Strobe timing checker for scd_ctrl.
 Assumes it is bound into scd_ctrl and sees its ports only.
*/
`timescale 1ns/1ps
module scd_ctrl_checker
	import scd_pkg::*;
#(
	parameter int unsigned PWRUP_CYC    = 20,  // Power-up pause
	parameter int unsigned RASC_MAX_CYC = 40   // Row open limit
) (
	input wire logic                  SYS_CLK,            // Clock
	input wire logic                  RST_N,              // Reset, low
	input wire logic                  INIT_DONE,          // Start-up over
	input wire logic                  RAS_N,              // Row strobe
	input wire logic                  CS_N,               // Column strobe
	input wire logic                  NINTH_BIT_STROBE_N, // Bit 9
	input wire logic                  WE_N,               // Write strobe
	input wire logic [scd_pkg::ADDR_W-1:0] ADDR           // Mux address
);
	logic [15:0] up_q, up_d;     // Cycles since reset
	logic [15:0] age_q, age_d;   // Cycles since row opened
	logic [3:0]  nras_q, nras_d; // Row strobe falls since reset
	logic [1:0]  nwe_q, nwe_d;   // Write falls in this row
	logic        ras_q, we_q;    // Last strobe levels
	// Next helper values; all counts but the row age saturate so they never wrap
	always_comb
	begin
		up_d = (up_q == 16'hffff) ? up_q : up_q + 16'h1;
		age_d = RAS_N ? 16'h0 : age_q + 16'h1;
		nras_d = nras_q;
		if (ras_q && !RAS_N && nras_q != 4'hf)
			nras_d = nras_q + 4'h1;
		nwe_d = RAS_N ? 2'h0 : nwe_q;
		if (!RAS_N && we_q && !WE_N && nwe_q != 2'h3)
			nwe_d = nwe_q + 2'h1;
	end
	// Helper registers
	always_ff @(posedge SYS_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			{up_q, age_q, nras_q, nwe_q} <= '0;
			{ras_q, we_q} <= 2'h3;
		end
		else
		begin
			{up_q, age_q, nras_q, nwe_q} <= {up_d, age_d, nras_d, nwe_d};
			{ras_q, we_q} <= {RAS_N, WE_N};
		end
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	a_pwrup_quiet: assert property (up_q < PWRUP_CYC |-> RAS_N && CS_N)
		else $error("strobe active during power-up pause");
	a_init_eight: assert property ($rose(INIT_DONE) |-> nras_q >= 4'h8)
		else $error("start-up ended before eight row cycles");
	a_cbr_lead: assert property ($fell(RAS_N) && !CS_N |-> !$past(CS_N))
		else $error("column strobe not ahead of row strobe");
	a_col_precharge: assert property ($fell(RAS_N) && CS_N |->
		$past(CS_N) && $past(NINTH_BIT_STROBE_N))
		else $error("column strobe precharge too short");
	a_row_min: assert property ($fell(RAS_N) |=> !RAS_N [*7])
		else $error("row strobe pulse too short");
	a_row_max: assert property (!RAS_N |-> age_q < RASC_MAX_CYC)
		else $error("row strobe held too long");
	a_read_hold: assert property ($rose(CS_N) && $past(WE_N) |-> WE_N)
		else $error("write strobe fell at read end");
	a_early_write: assert property ($fell(CS_N) && !WE_N |->
		!WE_N ##1 !WE_N)
		else $error("early write hold too short");
	a_second_write: assert property ($fell(WE_N) && !RAS_N &&
		nwe_q != 2'h0 |-> age_q >= 16'd10)
		else $error("second write too soon after row strobe");
	a_addr_hold: assert property ($fell(WE_N) && !RAS_N && !CS_N |=>
		(RAS_N || $stable(ADDR)) [*8])
		else $error("column address moved too soon after write");
	c_cbr: cover property ($fell(RAS_N) && !CS_N);
	c_sc_write: cover property ($fell(WE_N) && !CS_N && !RAS_N);
	c_rmw: cover property ($fell(WE_N) && CS_N && !NINTH_BIT_STROBE_N);
endmodule : scd_ctrl_checker
bind scd_ctrl scd_ctrl_checker #(
	.PWRUP_CYC(PWRUP_CYC), .RASC_MAX_CYC(RASC_MAX_CYC)
) u_chk (
	.SYS_CLK(SYS_CLK), .RST_N(RST_N), .INIT_DONE(INIT_DONE),
	.RAS_N(RAS_N), .CS_N(CS_N), .WE_N(WE_N), .ADDR(ADDR),
	.NINTH_BIT_STROBE_N(NINTH_BIT_STROBE_N)
);

//--- bench/tb_scd_ctrl.sv
/*
 Self-checking bench for scd_ctrl driving a behavioural memory.
 Assumes the checker file binds itself into scd_ctrl.
*/
`timescale 1ns/1ps
module tb_scd_ctrl;
	import scd_pkg::*;
	typedef struct packed {
		scd_req_t          r;  // Request
		logic [WORD_W-1:0] e;  // Expected read word
	} scd_row_t;
	logic              clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
	scd_req_t          req = '0;
	logic              req_ready, rsp_valid, init_done, dq_oe, d9_to;
	logic              ras_n, cs_n, nine_n, we_n, d9_from;
	logic              ras_p = 1'b1;  // Last row strobe
	logic [WORD_W-1:0] rsp_data, d;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0]   dq_i, dq_o;
	int                num_errors = 0, checks = 0, ncbr = 0, n, n0 = 0;
	// Same row pairs run static-column unless the first is an rmw or the row must close first, as rows 1 and 2 do at the row limit; others reopen rows
	scd_row_t rows [10] = '{
		'{'{1'b1, 1'b0, 20'h01003, 9'h1a5}, 9'h000},
		'{'{1'b1, 1'b0, 20'h01007, 9'h05a}, 9'h000},
		'{'{1'b0, 1'b0, 20'h01003, 9'h000}, 9'h1a5},
		'{'{1'b0, 1'b0, 20'h01007, 9'h000}, 9'h05a},
		'{'{1'b1, 1'b0, 20'h02003, 9'h133}, 9'h000},
		'{'{1'b0, 1'b0, 20'h01003, 9'h000}, 9'h1a5},
		'{'{1'b0, 1'b1, 20'h02003, 9'h000}, 9'h100},
		'{'{1'b0, 1'b0, 20'h02003, 9'h000}, 9'h033},
		'{'{1'b1, 1'b0, 20'hfffff, 9'h1ff}, 9'h000},
		'{'{1'b0, 1'b0, 20'hfffff, 9'h000}, 9'h1ff}};
	always #5 clk = ~clk;
	scd_ctrl #(.PWRUP_CYC(20), .REF_PERIOD_CYC(32768), .RASC_MAX_CYC(40))
	uut (
		.SYS_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid),
		.RSP_DATA(rsp_data), .INIT_DONE(init_done), .RAS_N(ras_n),
		.CS_N(cs_n), .NINTH_BIT_STROBE_N(nine_n), .WE_N(we_n),
		.ADDR(addr), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe),
		.D9_TO_MEM(d9_to), .D9_FROM_MEM(d9_from));
	scd_mem_model u_mem (
		.clk(clk), .ras_n(ras_n), .cs_n(cs_n), .cs9_n(nine_n),
		.we_n(we_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe),
		.d9_in(d9_to), .dq_i(dq_i), .d9_out(d9_from));
	// Count refresh cycles: column strobe low when the row falls
	always @(posedge clk)
	begin
		ras_p <= ras_n;
		if (ras_p && !ras_n && !cs_n)
			ncbr <= ncbr + 1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// One request, held until taken, then wait for its answer
	task automatic xfer(input scd_req_t r, output logic [WORD_W-1:0] q);
		int k;
		k = 0;
		@(negedge clk);
		req = r;
		req_valid = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1 && ++k < 500);
		@(negedge clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && ++k < 1000)
			@(negedge clk);
		q = rsp_data;
		chk(16'(k < 1000), 16'h1);
	endtask : xfer
	// Wait for start-up to finish, counting cycles
	task automatic wait_init;
		n = 0;
		while (init_done !== 1'b1 && ++n < 2000)
			@(negedge clk);
	endtask : wait_init
	task automatic results;
		$display("errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results
	// Cut a hang well past the expected run of under two thousand cycles
	initial
	begin
		#200000;
		num_errors++;
		results();
	end
	initial
	begin
		repeat (16) @(negedge clk);
		chk({ras_n, cs_n, nine_n, we_n, dq_oe, rsp_valid, init_done},
			16'h0078);
		n0 = ncbr;
		rst_n = 1'b1;
		wait_init();
		chk(16'(n >= 20 && n < 2000), 16'h1);
		chk(16'(ncbr - n0 >= 8), 16'h1);
		foreach (rows[i])
		begin
			xfer(rows[i].r, d);
			if (!rows[i].r.write || rows[i].r.rmw)
				chk(16'(d), 16'(rows[i].e));
		end
		// Idle long enough for ten refresh intervals
		n0 = ncbr;
		repeat (640) @(negedge clk);
		chk(16'(ncbr - n0 >= 9), 16'h1);
		// Second reset in mid-run; stored data survives
		rst_n = 1'b0;
		@(negedge clk);
		chk({ras_n, cs_n, nine_n, we_n, dq_oe, rsp_valid, init_done},
			16'h0078);
		n0 = ncbr;
		rst_n = 1'b1;
		wait_init();
		chk(16'(ncbr - n0 >= 8 && n < 2000), 16'h1);
		xfer(rows[9].r, d);
		chk(16'(d), 16'(rows[9].e));
		results();
	end
endmodule : tb_scd_ctrl
